// >>> common/eeprom_host_pkg.sv
package eeprom_host_pkg;
    // pin widths and page geometry
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int PAGE_BYTES = 64;
    localparam int PAGE_W = 6;
    localparam logic [6:0] PAGE_CNT_RESET = 7'h00;
    // status bit positions in a read byte
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    // identification area
    localparam logic [ADDR_W-1:0] ID_AREA_BASE = 13'h1fc0;
    localparam logic [ADDR_W-1:0] ID_AREA_LAST = 13'h1fff;
    // protection command sequence, arbitrary fixed values, used directly by host and model
    localparam logic [ADDR_W-1:0] CMD_ADDR0 = 13'h1555;
    localparam logic [ADDR_W-1:0] CMD_ADDR1 = 13'h0aaa;
    localparam logic [ADDR_W-1:0] CMD_ADDR2 = 13'h1555;
    localparam logic [DATA_W-1:0] CMD_DATA0 = 8'haa;
    localparam logic [DATA_W-1:0] CMD_DATA1 = 8'h55;
    localparam logic [DATA_W-1:0] CMD_DATA_ENABLE = 8'ha0;
    localparam logic [DATA_W-1:0] CMD_DATA_DISABLE = 8'h20;
    localparam logic [DATA_W-1:0] CMD_DATA_DISABLE1 = 8'h80;
    // timing
    localparam int CLK_MHZ = 250;
    localparam int CLK_PERIOD_NS = 4;
    localparam int WRITE_PULSE_NS = 100;
    localparam int DATA_SETUP_NS = 50;
    localparam int ADDR_HOLD_NS = 50;
    localparam int READ_ACCESS_NS = 70;
    localparam int FLOAT_NS = 35;
    localparam int BYTE_LOAD_WINDOW_US = 150;
    localparam int WRITE_CYCLE_TIME_US = 2000;
    localparam int POWER_ON_DELAY_US = 5000;
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest time: round down
    localparam int BYTE_LOAD_WINDOW_CYC = BYTE_LOAD_WINDOW_US * CLK_MHZ;
    localparam int WRITE_CYCLE_TIME_CYC = WRITE_CYCLE_TIME_US * CLK_MHZ;
    localparam int POWER_ON_DELAY_CYC = POWER_ON_DELAY_US * CLK_MHZ;
    localparam int TIMER_W = 24;
    // host command codes
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_PAGE_END = 2'h2;
    typedef enum logic [1:0] {PROT_NONE, PROT_ENABLE, PROT_UNLOCK, PROT_DISABLE} prot_e;
endpackage : eeprom_host_pkg

// >>> src/bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
// one strobe-timed bus access: a read or a write-enable controlled write
module bus_cycle
    import eeprom_host_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clkEn,
    // request
    input wire logic start,
    input wire logic isWrite,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    // pins
    output logic chipSel_b,
    output logic outGate_b,
    output logic writeStb_b,
    output logic [ADDR_W-1:0] addrPin,
    input wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe
);
    typedef enum logic [2:0] {IDLE, SETUP, PULSE, HOLD, RECOVER} cyc_e;
    cyc_e state_reg;
    logic [7:0] cnt_reg;
    logic wr_reg;
    logic [DATA_W-1:0] sync1_reg, sync2_reg;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else if (clkEn) begin
            sync1_reg <= dataIn;
            sync2_reg <= sync1_reg;
        end
    end

    assign done = (state_reg == RECOVER) && (cnt_reg == 8'h00);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= IDLE;
            cnt_reg <= 8'h00;
            wr_reg <= 1'b0;
            chipSel_b <= 1'b1;
            outGate_b <= 1'b1;
            writeStb_b <= 1'b1;
            addrPin <= '0;
            dataOut <= 8'h00;
            dataOe <= 1'b0;
            rdata <= 8'h00;
        end else if (clkEn) begin
            unique case (state_reg)
                IDLE: if (start) begin
                    wr_reg <= isWrite;
                    addrPin <= addr;
                    dataOut <= wdata;
                    chipSel_b <= 1'b0;
                    outGate_b <= isWrite; // gate high during writes
                    state_reg <= SETUP;
                end
                SETUP: begin
                    // strobe falls last so address is taken on it
                    if (wr_reg) begin
                        writeStb_b <= 1'b0;
                        dataOe <= 1'b1;
                        cnt_reg <= 8'(WRITE_PULSE_CYC);
                    end else begin
                        cnt_reg <= 8'(READ_ACCESS_CYC + 2);
                    end
                    state_reg <= PULSE;
                end
                PULSE: if (cnt_reg != 8'h00) begin
                    cnt_reg <= cnt_reg - 8'h01;
                end else begin
                    // strobe rises before chip select, data latched on it
                    if (wr_reg) writeStb_b <= 1'b1;
                    else rdata <= sync2_reg;
                    outGate_b <= 1'b1;
                    cnt_reg <= 8'(ADDR_HOLD_CYC);
                    state_reg <= HOLD;
                end
                HOLD: if (cnt_reg != 8'h00) begin
                    cnt_reg <= cnt_reg - 8'h01;
                end else begin
                    chipSel_b <= 1'b1;
                    dataOe <= 1'b0;
                    // bus turnaround before next access
                    cnt_reg <= 8'(FLOAT_CYC);
                    state_reg <= RECOVER;
                end
                RECOVER: if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
                    else state_reg <= IDLE;
            endcase
        end
    end
endmodule : bus_cycle
`default_nettype wire

// >>> src/eeprom_host.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - write starts on low strobe with select low and gate high
// - host loads next page byte within 150 us of previous
// - host keeps upper address bits A6..A12 fixed across a page
// - protected writes need the sequence right before data bytes
// - sequence bytes use page timing and are not stored
// - host starts new access only after end of write detected or write timeout flagged
module eeprom_host
    import eeprom_host_pkg::*;
#(
    parameter int BYTE_LOAD_CYC = BYTE_LOAD_WINDOW_CYC,
    parameter int WRITE_TIMEOUT_CYC = WRITE_CYCLE_TIME_CYC,
    parameter int POWER_ON_CYC = POWER_ON_DELAY_CYC
)(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clkEn,
    // user command
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [1:0] cmdOp,
    input wire logic [ADDR_W-1:0] cmdAddr,
    input wire logic [DATA_W-1:0] cmdData,
    input wire logic cmdIdArea,
    input wire logic [1:0] cmdProt,
    // user answer
    output logic rspValid,
    output logic [DATA_W-1:0] rspData,
    output logic writeBusy,
    output logic writeTimeout,
    output logic protEnabled,
    // device pins
    output logic chipSel_b,
    output logic outGate_b,
    output logic writeStb_b,
    output logic [ADDR_W-1:0] addrPin,
    output logic identification_select,
    input wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe
);
    typedef enum logic [2:0] {POWERUP, IDLE, CMDSEQ, ACCESS, POLL, POLLWAIT} host_e;
    host_e state_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] window_reg;
    logic [2:0] seqIdx_reg;
    logic [2:0] seqLen_reg;
    logic [6:0] pageCnt_reg;
    logic pageOpen_reg;
    logic [ADDR_W-1:6] pageBase_reg;
    logic [ADDR_W-1:0] lastAddr_reg;
    logic [DATA_W-1:0] lastData_reg;
    logic [DATA_W-1:0] prevRead_reg;
    logic pollFirst_reg;
    logic isRead_reg;
    logic cycStart, cycWrite, cycDone;
    logic [ADDR_W-1:0] cycAddr;
    logic [DATA_W-1:0] cycData, cycRdata;

    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] i);
        unique case (i)
            3'h0, 3'h3: seq_addr = CMD_ADDR0;
            3'h1, 3'h4: seq_addr = CMD_ADDR1;
            default: seq_addr = CMD_ADDR2;
        endcase
    endfunction : seq_addr

    function automatic logic [DATA_W-1:0] seq_data(input logic [2:0] i, input prot_e p);
        unique case (i)
            3'h0, 3'h3: seq_data = CMD_DATA0;
            3'h1, 3'h4: seq_data = CMD_DATA1;
            3'h2: seq_data = (p == PROT_DISABLE) ? CMD_DATA_DISABLE1 : CMD_DATA_ENABLE;
            default: seq_data = CMD_DATA_DISABLE;
        endcase
    endfunction : seq_data

    prot_e prot_reg;

    ////////////////////////////////////////////////////////////////////////////
    // not ready in the window's last cycle, where the page is being closed
    assign cmdReady = clkEn && !cycStart && state_reg == IDLE &&
        !(pageOpen_reg && window_reg >= TIMER_W'(BYTE_LOAD_CYC - 1));
    assign writeBusy = (state_reg == POLL) || (state_reg == POLLWAIT);
    assign cycWrite = !isRead_reg;
    assign cycStart = (state_reg == ACCESS) || (state_reg == POLL) ||
        (state_reg == CMDSEQ && seqIdx_reg != seqLen_reg);
    assign cycAddr = (state_reg == POLL) ? lastAddr_reg :
        (state_reg == CMDSEQ) ? seq_addr(seqIdx_reg) : lastAddr_reg;
    assign cycData = (state_reg == CMDSEQ) ? seq_data(seqIdx_reg, prot_reg) : lastData_reg;

    // stepping one state per access; bus_cycle latches start only in its idle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= POWERUP;
            timer_reg <= '0;
            window_reg <= '0;
            seqIdx_reg <= 3'h0;
            seqLen_reg <= 3'h0;
            pageCnt_reg <= PAGE_CNT_RESET;
            pageOpen_reg <= 1'b0;
            pageBase_reg <= '0;
            lastAddr_reg <= '0;
            lastData_reg <= 8'h00;
            prevRead_reg <= 8'h00;
            pollFirst_reg <= 1'b0;
            isRead_reg <= 1'b0;
            prot_reg <= PROT_NONE;
            rspValid <= 1'b0;
            rspData <= 8'h00;
            writeTimeout <= 1'b0;
            protEnabled <= 1'b0;
            identification_select <= 1'b0;
        end else if (clkEn) begin
            rspValid <= 1'b0;
            // byte-load window: close page if no byte follows in time
            if (pageOpen_reg && state_reg == IDLE) begin
                if (window_reg >= TIMER_W'(BYTE_LOAD_CYC - 1) || cmdOp == OP_PAGE_END && cmdValid) begin
                    pageOpen_reg <= 1'b0;
                    state_reg <= POLL;
                    pollFirst_reg <= 1'b1;
                    timer_reg <= '0;
                end else begin
                    window_reg <= window_reg + 1'b1;
                end
            end
            unique case (state_reg)
                POWERUP: if (timer_reg >= TIMER_W'(POWER_ON_CYC - 1)) begin
                    state_reg <= IDLE;
                    timer_reg <= '0;
                end else timer_reg <= timer_reg + 1'b1;
                IDLE: if (cmdValid && cmdReady && cmdOp != OP_PAGE_END) begin
                    isRead_reg <= (cmdOp == OP_READ);
                    identification_select <= cmdIdArea && cmdAddr >= ID_AREA_BASE;
                    // page bits locked on first byte, low bits free
                    lastAddr_reg <= pageOpen_reg ? {pageBase_reg, cmdAddr[PAGE_W-1:0]} : cmdAddr;
                    lastData_reg <= cmdData;
                    if (!pageOpen_reg && cmdOp == OP_WRITE && prot_e'(cmdProt) != PROT_NONE
                        && state_reg == IDLE) begin
                        // sequence precedes data, page timing kept
                        prot_reg <= prot_e'(cmdProt);
                        seqIdx_reg <= 3'h0;
                        seqLen_reg <= (prot_e'(cmdProt) == PROT_DISABLE) ? 3'h6 : 3'h3;
                        state_reg <= CMDSEQ;
                    end else state_reg <= ACCESS;
                end
                CMDSEQ: if (cycDone) begin
                    // the carried data byte follows the last sequence write
                    if (seqIdx_reg == seqLen_reg - 3'h1) state_reg <= ACCESS;
                    seqIdx_reg <= seqIdx_reg + 3'h1;
                end
                ACCESS: if (cycDone) begin
                    if (isRead_reg) begin
                        rspValid <= 1'b1;
                        rspData <= cycRdata;
                        state_reg <= IDLE;
                    end else begin
                        if (!pageOpen_reg) begin
                            pageBase_reg <= lastAddr_reg[ADDR_W-1:6];
                            pageCnt_reg <= 7'h01;
                        end else pageCnt_reg <= pageCnt_reg + 7'h01;
                        pageOpen_reg <= 1'b1;
                        window_reg <= '0;
                        if (prot_reg == PROT_ENABLE) protEnabled <= 1'b1;
                        if (prot_reg == PROT_DISABLE) protEnabled <= 1'b0;
                        prot_reg <= PROT_NONE;
                        // full page goes straight to programming
                        state_reg <= (pageOpen_reg && pageCnt_reg == 7'(PAGE_BYTES - 1)) ? POLL : IDLE;
                        pollFirst_reg <= 1'b1;
                        timer_reg <= '0;
                    end
                end
                default: begin
                    // status polling
                    if (state_reg == POLL || state_reg == POLLWAIT) begin
                        timer_reg <= timer_reg + 1'b1;
                        if (state_reg == POLL) state_reg <= POLLWAIT;
                        if (cycDone) begin
                            pollFirst_reg <= 1'b0;
                            prevRead_reg <= cycRdata;
                            // true data and no toggle means done
                            if (cycRdata[POLL_BIT] == lastData_reg[POLL_BIT] &&
                                (pollFirst_reg == 1'b0) &&
                                cycRdata[TOGGLE_BIT] == prevRead_reg[TOGGLE_BIT]) begin
                                state_reg <= IDLE;
                                pageOpen_reg <= 1'b0;
                            end else if (timer_reg >= TIMER_W'(WRITE_TIMEOUT_CYC - 1)) begin
                                writeTimeout <= 1'b1;
                                state_reg <= IDLE;
                                pageOpen_reg <= 1'b0;
                            end else state_reg <= POLL;
                        end
                    end
                end
            endcase
            if (state_reg == POLL) isRead_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin timing kept in bus_cycle; strobes never overlap gate low
    bus_cycle u_cycle (
        .mclk(mclk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .start(cycStart),
        .isWrite(state_reg == POLL ? 1'b0 : (state_reg == CMDSEQ ? 1'b1 : cycWrite)),
        .addr(cycAddr),
        .wdata(cycData),
        .done(cycDone),
        .rdata(cycRdata),
        .chipSel_b(chipSel_b),
        .outGate_b(outGate_b),
        .writeStb_b(writeStb_b),
        .addrPin(addrPin),
        .dataIn(dataIn),
        .dataOut(dataOut),
        .dataOe(dataOe)
    );
endmodule : eeprom_host
`default_nettype wire

// >>> tb/eeprom_host_checker.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_checker
    import eeprom_host_pkg::*;
#(
    parameter int BYTE_LOAD_CYC = BYTE_LOAD_WINDOW_CYC,
    parameter int POWER_ON_CYC = POWER_ON_DELAY_CYC
)(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // user side
    input wire logic cmdReady,
    input wire logic writeBusy,
    // device pins
    input wire logic chipSel_b,
    input wire logic outGate_b,
    input wire logic writeStb_b,
    input wire logic [ADDR_W-1:0] addrPin,
    input wire logic identification_select,
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataOe
);
    int poCnt;
    int lowCnt;
    int gapCnt;
    logic busySeen;
    logic [6:0] lastUpper;
    logic cmdHit;
    assign cmdHit = addrPin inside {CMD_ADDR0, CMD_ADDR1, CMD_ADDR2};
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) poCnt <= 0;
        else if (poCnt < POWER_ON_CYC) poCnt <= poCnt + 1;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) lowCnt <= 0;
        else lowCnt <= writeStb_b ? 0 : lowCnt + 1;
    end
    // busySeen starts set: no page is open after reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gapCnt <= 0;
            busySeen <= 1'b1;
            lastUpper <= 7'h00;
        end else if ($fell(writeStb_b) && !cmdHit) begin
            gapCnt <= 0;
            busySeen <= 1'b0;
            lastUpper <= addrPin[12:6];
        end else begin
            gapCnt <= gapCnt + 1;
            if (writeBusy) busySeen <= 1'b1;
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    host_no_fight_a: assert property (dataOe |-> outGate_b) else $error("host drives with gate low");
    write_gate_a: assert property (!writeStb_b |-> outGate_b && !chipSel_b) else $error("bad write gating");
    strobe_width_a: assert property ($rose(writeStb_b) |-> lowCnt >= WRITE_PULSE_CYC) else $error("short strobe");
    write_data_a: assert property (!writeStb_b && $past(!writeStb_b) |-> dataOe && $stable(dataOut))
        else $error("data moved in strobe");
    addr_hold_a: assert property (!chipSel_b && $past(!chipSel_b) |-> $stable(addrPin)) else $error("address moved");
    power_wait_a: assert property (poCnt < POWER_ON_CYC - 1 |-> !cmdReady && chipSel_b) else $error("early access");
    id_area_a: assert property (identification_select && !chipSel_b |-> addrPin >= ID_AREA_BASE)
        else $error("id select outside area");
    page_hold_a: assert property ($fell(writeStb_b) && !cmdHit && gapCnt < BYTE_LOAD_CYC && !busySeen |->
        addrPin[12:6] == lastUpper) else $error("page bits changed");
    read_gate_a: assert property (!outGate_b |-> writeStb_b && !dataOe) else $error("read with strobe");
    poll_no_write_a: assert property (writeBusy |-> writeStb_b) else $error("write during poll");
endmodule : eeprom_host_checker
bind eeprom_host eeprom_host_checker #(.BYTE_LOAD_CYC(BYTE_LOAD_CYC), .POWER_ON_CYC(POWER_ON_CYC)) u_eeprom_host_checker (
    .mclk, .rst_b, .cmdReady, .writeBusy, .chipSel_b, .outGate_b, .writeStb_b, .addrPin,
    .identification_select, .dataOut, .dataOe);
`default_nettype wire

// >>> tb/eeprom_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_tb;
    import eeprom_host_pkg::*;
    localparam int PO_CYC = 50;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic cmdValid = 1'b0;
    logic cmdIdArea = 1'b0;
    logic [1:0] cmdOp = 2'h0;
    logic [1:0] cmdProt = 2'h0;
    logic protEnabled;
    logic [ADDR_W-1:0] cmdAddr = 13'h0000;
    logic [DATA_W-1:0] cmdData = 8'h00;
    logic cmdReady, rspValid, writeBusy, writeTimeout, chipSel_b, outGate_b, writeStb_b, identification_select, dataOe;
    logic [DATA_W-1:0] rspData, dataOut, busData;
    logic [ADDR_W-1:0] addrPin;
    int errors = 0;
    int checks = 0;
    always #2 mclk = ~mclk;
    eeprom_host #(.BYTE_LOAD_CYC(200), .WRITE_TIMEOUT_CYC(2000), .POWER_ON_CYC(PO_CYC)) u_eeprom_host (
        .mclk, .rst_b, .clkEn(1'b1), .cmdValid, .cmdReady, .cmdOp, .cmdAddr, .cmdData, .cmdIdArea,
        .cmdProt, .rspValid, .rspData, .writeBusy, .writeTimeout, .protEnabled, .chipSel_b,
        .outGate_b, .writeStb_b, .addrPin, .identification_select, .dataIn(busData), .dataOut, .dataOe);
    eeprom_model u_eeprom_model (.mclk, .rst_b, .chipSel_b, .outGate_b, .writeStb_b, .addrPin,
        .identification_select, .hostData(dataOut), .hostOe(dataOe), .busData);
    ////////////////////////////////////////
    task automatic end_of_test();
        if (errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic check_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_flag(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask : check_flag
    task automatic timed_out();
        check_flag(1'b0, 1'b1);
        end_of_test();
    endtask : timed_out
    // one edge passes first, so valid is never set twice in one step
    task automatic issue(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic id);
        int n;
        n = 0;
        @(posedge mclk);
        cmdOp <= op;
        cmdAddr <= a;
        cmdData <= d;
        cmdIdArea <= id;
        cmdValid <= 1'b1;
        @(negedge mclk);
        while (cmdReady !== 1'b1 && n < 4000) begin
            @(negedge mclk);
            n++;
        end
        @(posedge mclk);
        cmdValid <= 1'b0;
        if (n >= 4000) timed_out();
    endtask : issue
    task automatic issue_prot(input logic [1:0] p, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        cmdProt <= p;
        issue(OP_WRITE, a, d, 1'b0);
        cmdProt <= 2'h0;
    endtask : issue_prot
    task automatic read_check(input logic [ADDR_W-1:0] a, input logic id, input logic [DATA_W-1:0] exp);
        int n;
        n = 0;
        issue(OP_READ, a, 8'h00, id);
        while (rspValid !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 200) timed_out();
        check_byte(rspData, exp);
    endtask : read_check
    task automatic wait_program();
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        while (!(seen && writeBusy === 1'b0) && n < 3000) begin
            @(negedge mclk);
            n++;
            if (writeBusy === 1'b1) seen = 1'b1;
        end
        if (n >= 3000) timed_out();
        check_flag(seen, 1'b1);
        check_flag(writeTimeout, 1'b0);
    endtask : wait_program
    ////////////////////////////////////////
    task automatic test_power_on();
        repeat (PO_CYC - 5) @(negedge mclk);
        check_flag(cmdReady, 1'b0);
        read_check(13'h0000, 1'b0, 8'hff);
    endtask : test_power_on
    task automatic test_page_order();
        issue(OP_WRITE, 13'h0145, 8'h11, 1'b0);
        issue(OP_WRITE, 13'h0142, 8'h22, 1'b0);
        issue(OP_WRITE, 13'h0145, 8'h33, 1'b0);
        repeat (100) @(negedge mclk);
        check_flag(writeBusy, 1'b0);
        wait_program();
        read_check(13'h0145, 1'b0, 8'h33);
        read_check(13'h0142, 1'b0, 8'h22);
        read_check(13'h0143, 1'b0, 8'hff);
    endtask : test_page_order
    task automatic test_full_page();
        for (int i = 63; i >= 0; i--) issue(OP_WRITE, {7'h20, 6'(i)}, 8'(i) ^ 8'h5a, 1'b0);
        wait_program();
        for (int i = 0; i < 64; i++) read_check({7'h20, 6'(i)}, 1'b0, 8'(i) ^ 8'h5a);
    endtask : test_full_page
    task automatic test_id_area();
        issue(OP_WRITE, ID_AREA_BASE + 13'h0003, 8'h3c, 1'b0);
        wait_program();
        issue(OP_WRITE, ID_AREA_BASE + 13'h0003, 8'hc3, 1'b1);
        wait_program();
        read_check(ID_AREA_BASE + 13'h0003, 1'b1, 8'hc3);
        read_check(ID_AREA_BASE + 13'h0003, 1'b0, 8'h3c);
    endtask : test_id_area
    task automatic test_protect();
        issue_prot(2'h1, 13'h0203, 8'h4e);
        wait_program();
        check_flag(protEnabled, 1'b1);
        read_check(13'h0203, 1'b0, 8'h4e);
        read_check(CMD_ADDR1, 1'b0, 8'hff);
        issue(OP_WRITE, 13'h0204, 8'h81, 1'b0);
        wait_program();
        read_check(13'h0204, 1'b0, 8'hff);
        issue_prot(2'h3, 13'h0205, 8'h12);
        issue(OP_PAGE_END, 13'h0000, 8'h00, 1'b0);
        wait_program();
        check_flag(protEnabled, 1'b0);
        read_check(13'h0205, 1'b0, 8'h12);
    endtask : test_protect
    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        test_power_on();
        test_page_order();
        test_full_page();
        test_id_area();
        test_protect();
        end_of_test();
    end
endmodule : eeprom_host_tb
`default_nettype wire

// >>> tb/eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_model
    import eeprom_host_pkg::*;
#(
    parameter int LOAD_WIN = 150,
    parameter int WRITE_CYC = 300,
    parameter int PO_CYC = 40
)(
    // host pins
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic chipSel_b,
    input wire logic outGate_b,
    input wire logic writeStb_b,
    input wire logic [ADDR_W-1:0] addrPin,
    input wire logic identification_select,
    input wire logic [DATA_W-1:0] hostData,
    input wire logic hostOe,
    // resolved data bus
    output logic [DATA_W-1:0] busData
);
    logic [DATA_W-1:0] mem [0:16383];
    logic [DATA_W-1:0] pageBuf [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] pageMask = '0;
    logic [13:0] latAddr, pageBase, rdAddr;
    logic [DATA_W-1:0] lastData = 8'h00;
    logic [DATA_W-1:0] lastBus = 8'h00;
    logic wrAct, rdAct, wrActD = 1'b0, rdActD = 1'b0, loading = 1'b0, busy = 1'b0, tog = 1'b0;
    int loadCnt = 0, wcCnt = 0, poCnt = 0, rdCnt = 0, seqStep = 0;
    // protection survives reset
    logic software_write_protection = 1'b0, unlocked = 1'b0;
    function automatic logic seq_hit(input int s, input logic [12:0] a, input logic [7:0] d);
        case (s)
            0, 3: seq_hit = a == CMD_ADDR0 && d == CMD_DATA0;
            1, 4: seq_hit = a == CMD_ADDR1 && d == CMD_DATA1;
            2: seq_hit = a == CMD_ADDR2 && (d == CMD_DATA_ENABLE || d == CMD_DATA_DISABLE1);
            default: seq_hit = a == CMD_ADDR2 && d == CMD_DATA_DISABLE;
        endcase
    endfunction : seq_hit
    initial for (int i = 0; i < 16384; i++) mem[i] = 8'hff;
    assign wrAct = !chipSel_b && !writeStb_b && outGate_b;
    assign rdAct = !chipSel_b && !outGate_b && writeStb_b;
    assign rdAddr = {identification_select && addrPin >= ID_AREA_BASE, addrPin};
    // released bus shows a changing pattern, never the last value
    assign busData = hostOe ? hostData : (rdAct && rdCnt >= READ_ACCESS_CYC / 2) ?
        (busy ? {~lastData[POLL_BIT], tog, lastData[5:0]} : mem[rdAddr]) : ~lastBus;
    ////////////////////////////////////////
    always @(posedge mclk) begin
        wrActD <= wrAct;
        rdActD <= rdAct;
        lastBus <= busData;
        rdCnt <= rdAct ? rdCnt + 1 : 0;
        if (!rst_b) poCnt <= 0;
        else if (poCnt < PO_CYC) poCnt <= poCnt + 1;
        if (wrAct && !wrActD) latAddr <= rdAddr;
        if (!wrAct && wrActD && !busy && poCnt >= PO_CYC) begin
            seqStep <= !seq_hit(seqStep, latAddr[12:0], hostData) || seqStep == 5 ||
                seqStep == 2 && hostData == CMD_DATA_ENABLE ? 0 : seqStep + 1;
            if (seq_hit(seqStep, latAddr[12:0], hostData)) begin
                if (seqStep == 2 && hostData == CMD_DATA_ENABLE) {software_write_protection, unlocked} <= 2'b11;
                if (seqStep == 5) {software_write_protection, unlocked} <= 2'b01;
            end else if (!software_write_protection || unlocked) begin
                if (pageMask == '0) pageBase <= latAddr;
                pageBuf[latAddr[5:0]] <= hostData;
                pageMask[latAddr[5:0]] <= 1'b1;
            end
            lastData <= hostData;
            loading <= 1'b1;
            loadCnt <= 0;
        end else if (loading && loadCnt >= LOAD_WIN) begin
            for (int i = 0; i < PAGE_BYTES; i++) if (pageMask[i]) mem[{pageBase[13:6], 6'(i)}] <= pageBuf[i];
            pageMask <= '0;
            unlocked <= 1'b0;
            loading <= 1'b0;
            busy <= 1'b1;
            wcCnt <= 0;
        end else if (loading) loadCnt <= loadCnt + 1;
        if (busy) begin
            if (wcCnt >= WRITE_CYC) busy <= 1'b0;
            else wcCnt <= wcCnt + 1;
        end
        if (rdAct && !rdActD && busy) tog <= !tog;
    end
endmodule : eeprom_model
`default_nettype wire
